// ### hw/sbsf_defines.vh
`ifndef SBSF_DEFINES_VH
`define SBSF_DEFINES_VH

// Register byte addresses
`define SBSF_ADR_STATUS   12'h424
`define SBSF_ADR_CONTROL  12'h428
`define SBSF_ADR_IRQ_MASK 12'h434
`define SBSF_ADR_W        12

// Status register fields
`define SBSF_TGT_ADDR_HI  7
`define SBSF_TGT_ADDR_LO  1
`define SBSF_INI_ADDR_HI  15
`define SBSF_INI_ADDR_LO  9
`define SBSF_BIT_DONE     24
`define SBSF_FLAG_LO      25
`define SBSF_FLAG_HI      29
`define SBSF_BIT_NACK     25
`define SBSF_BIT_ARB      26
`define SBSF_BIT_MISPL    27
`define SBSF_BIT_CSUM     28
`define SBSF_BIT_UNMAP    29

// Control register fields
`define SBSF_BIT_IGN_INI  16
`define SBSF_BIT_SKIP_CS  17

// Reset values
`define SBSF_FLAGS_RST    5'h00
`define SBSF_MASK_RST     5'h00
`define SBSF_ADDR_RST     7'h00
`define SBSF_WORD_ZERO    32'h00000000

// Arbitration retry limit and bus monitor counts
`define SBSF_ARB_LIMIT    5'h10
`define SBSF_ARB_ONE      5'h01
`define SBSF_ARB_ZERO     5'h00
`define SBSF_BITS_PER_B   4'h9
`define SBSF_BIT_ONE      4'h1
`define SBSF_BIT_ZERO     4'h0
`define SBSF_CSUM_ZERO    8'h00

`endif

// ### hw/sbsf_status_flags.v
`timescale 1ns/10ps
`default_nettype none
`include "sbsf_defines.vh"

// Operation
// - Target address readable at status bits 7:1
// - Initiator address readable at status bits 15:9
// - Boot done bit sets at end or error
// - Unexpected NACK sets write-one-clear flag 25
// - Retry arbitration; sixteenth loss aborts, sets 26
// - Misplaced START or STOP sets flag 27
// - Bad checksum or missing done sets 28
// - Load into unmapped register sets 29
// - Skip-checksum bit suppresses checksum errors
// - Ignore-initiators bit prevents arbitration aborts
module sbsf_status_flags (
    // System
    input  wire        clk_i,
    input  wire        rst_i,
    // Wishbone slave
    input  wire        cyc_i,
    input  wire        stb_i,
    input  wire        we_i,
    input  wire [11:0] adr_i,
    input  wire [3:0]  sel_i,
    input  wire [31:0] dat_i,
    output wire [31:0] dat_o,
    output wire        ack_o,
    // Hardware-initialised addresses and boot strap
    input  wire [6:0]  tgt_addr_strap_i,
    input  wire [6:0]  ini_addr_strap_i,
    input  wire        boot_from_eeprom_i,
    // Initiator transaction engine events
    input  wire        nack_seen_i,
    input  wire        arb_lost_i,
    input  wire        arb_won_i,
    // Boot loader events
    input  wire        boot_byte_valid_i,
    input  wire [7:0]  boot_byte_i,
    input  wire        boot_end_i,
    input  wire        cfg_done_found_i,
    input  wire        unmapped_load_i,
    // Initiator serial bus pins (other domain)
    input  wire        scl_pin_i,
    input  wire        sda_pin_i,
    // Engine controls and interrupt
    output wire        rearbitrate_o,
    output wire        abort_o,
    output wire        irq_o
);

    //------------------------------------------------------------
    // Register state
    //------------------------------------------------------------
    reg  [6:0]  target_port_bus_addr_r;
    reg  [6:0]  initiator_port_bus_addr_r;
    reg         strap_taken_r;
    reg  [6:0]  tgt_strap_s1_r;
    reg  [6:0]  ini_strap_s1_r;
    reg         boot_strap_s1_r;
    reg         boot_mode_r;
    reg         boot_load_complete_r;
    reg  [4:0]  flags_r;
    reg  [4:0]  flags_nxt;
    reg  [4:0]  mask_r;
    reg         ignore_competing_initiators_r;
    reg         skip_boot_checksum_r;
    reg  [31:0] dat_r;
    reg         ack_r;
    reg         irq_r;
    reg  [4:0]  arb_cnt_r;
    reg         rearb_r;
    reg         abort_r;
    reg  [7:0]  csum_r;
    reg         scl_s1_r;
    reg         scl_s2_r;
    reg         scl_q_r;
    reg         sda_s1_r;
    reg         sda_s2_r;
    reg         sda_q_r;
    reg         in_frame_r;
    reg  [3:0]  bit_cnt_r;

    wire [4:0]  ev_set;
    wire [31:0] status_word;
    wire [31:0] control_word;
    wire [31:0] mask_word;
    wire        bus_req;
    wire        wr_req;
    wire        wr_lane3;
    wire        wr_lane2;
    wire        scl_rise;
    wire        start_cond;
    wire        stop_cond;
    wire        mid_byte;
    wire        misplaced;
    wire        arb_abort;
    wire        csum_bad;
    wire        boot_err;

    //------------------------------------------------------------
    // Bus decode
    //------------------------------------------------------------
    // A new request is taken once; ack_r blocks a second take
    assign bus_req  = cyc_i & stb_i & ~ack_r;
    // Writes land on the edge where the master sees ack high, so a
    // request withdrawn before its answer changes nothing
    assign wr_req   = cyc_i & stb_i & we_i & ack_r;
    assign wr_lane3 = wr_req & sel_i[3];
    assign wr_lane2 = wr_req & sel_i[2];

    //------------------------------------------------------------
    // Strap capture
    //------------------------------------------------------------
    // First stage for the strap pins; kept out of reset so that it
    // already holds the pin levels when reset is released
    always @(posedge clk_i) begin
        tgt_strap_s1_r  <= tgt_addr_strap_i;
        ini_strap_s1_r  <= ini_addr_strap_i;
        boot_strap_s1_r <= boot_from_eeprom_i;
    end

    // Addresses and boot mode are caught on the first edge after
    // reset release; the reset itself only clears them to zero
    always @(posedge clk_i) begin
        if (rst_i) begin
            strap_taken_r             <= 1'b0;
            target_port_bus_addr_r    <= `SBSF_ADDR_RST;
            initiator_port_bus_addr_r <= `SBSF_ADDR_RST;
            boot_mode_r               <= 1'b0;
        end else if (!strap_taken_r) begin
            strap_taken_r             <= 1'b1;
            target_port_bus_addr_r    <= tgt_strap_s1_r;
            initiator_port_bus_addr_r <= ini_strap_s1_r;
            boot_mode_r               <= boot_strap_s1_r;
        end
    end

    //------------------------------------------------------------
    // Pin synchronisers and bus monitor
    //------------------------------------------------------------
    // Two stages per pin; edge logic reads stage two and its copy
    always @(posedge clk_i) begin
        if (rst_i) begin
            scl_s1_r <= 1'b1;
            scl_s2_r <= 1'b1;
            scl_q_r  <= 1'b1;
            sda_s1_r <= 1'b1;
            sda_s2_r <= 1'b1;
            sda_q_r  <= 1'b1;
        end else begin
            scl_s1_r <= scl_pin_i;
            scl_s2_r <= scl_s1_r;
            scl_q_r  <= scl_s2_r;
            sda_s1_r <= sda_pin_i;
            sda_s2_r <= sda_s1_r;
            sda_q_r  <= sda_s2_r;
        end
    end

    // START and STOP are SDA edges while SCL stays high
    assign scl_rise   = scl_s2_r & ~scl_q_r;
    assign start_cond = scl_s2_r & scl_q_r & ~sda_s2_r & sda_q_r;
    assign stop_cond  = scl_s2_r & scl_q_r & sda_s2_r & ~sda_q_r;
    // Inside a frame a condition is legal only on a byte boundary
    assign mid_byte   = in_frame_r & (bit_cnt_r != `SBSF_BIT_ZERO);
    assign misplaced  = (start_cond | stop_cond) & mid_byte;

    // Count clock pulses of each nine-bit byte-plus-ack slot
    always @(posedge clk_i) begin
        if (rst_i) begin
            in_frame_r <= 1'b0;
            bit_cnt_r  <= `SBSF_BIT_ZERO;
        end else if (start_cond) begin
            in_frame_r <= 1'b1;
            bit_cnt_r  <= `SBSF_BIT_ZERO;
        end else if (stop_cond) begin
            in_frame_r <= 1'b0;
            bit_cnt_r  <= `SBSF_BIT_ZERO;
        end else if (scl_rise && in_frame_r) begin
            if (bit_cnt_r == `SBSF_BITS_PER_B - `SBSF_BIT_ONE)
                bit_cnt_r <= `SBSF_BIT_ZERO;
            else
                bit_cnt_r <= bit_cnt_r + `SBSF_BIT_ONE;
        end
    end

    //------------------------------------------------------------
    // Arbitration retry counter
    //------------------------------------------------------------
    // Count consecutive losses; a win restarts the run. With the
    // ignore bit set the engine carries on, so nothing is counted
    assign arb_abort = arb_lost_i & ~ignore_competing_initiators_r
                     & (arb_cnt_r == `SBSF_ARB_LIMIT - `SBSF_ARB_ONE);

    always @(posedge clk_i) begin
        if (rst_i) begin
            arb_cnt_r <= `SBSF_ARB_ZERO;
            rearb_r   <= 1'b0;
            abort_r   <= 1'b0;
        end else begin
            rearb_r <= 1'b0;
            abort_r <= 1'b0;
            if (ignore_competing_initiators_r || arb_won_i) begin
                arb_cnt_r <= `SBSF_ARB_ZERO;
            end else if (arb_abort) begin
                arb_cnt_r <= `SBSF_ARB_ZERO;
                abort_r   <= 1'b1;
            end else if (arb_lost_i) begin
                arb_cnt_r <= arb_cnt_r + `SBSF_ARB_ONE;
                rearb_r   <= 1'b1;
            end
        end
    end

    //------------------------------------------------------------
    // Boot checksum and completion
    //------------------------------------------------------------
    // Bytes including the stored checksum must sum to zero
    always @(posedge clk_i) begin
        if (rst_i)
            csum_r <= `SBSF_CSUM_ZERO;
        else if (boot_byte_valid_i && boot_mode_r)
            csum_r <= csum_r + boot_byte_i;
    end

    // A skipped checksum always passes; a missing done still fails
    assign csum_bad = boot_mode_r & boot_end_i & ~skip_boot_checksum_r
                    & (csum_r != `SBSF_CSUM_ZERO);
    assign boot_err = boot_mode_r & ~boot_load_complete_r
                    & ((boot_end_i & ~cfg_done_found_i) | csum_bad
                       | unmapped_load_i);

    // Done only ever sets; it stays until the next reset
    always @(posedge clk_i) begin
        if (rst_i)
            boot_load_complete_r <= 1'b0;
        else if (boot_mode_r && (boot_end_i || boot_err))
            boot_load_complete_r <= 1'b1;
    end

    //------------------------------------------------------------
    // Error flags
    //------------------------------------------------------------
    assign ev_set[0] = nack_seen_i;
    assign ev_set[1] = arb_abort;
    assign ev_set[2] = misplaced;
    assign ev_set[3] = csum_bad | (boot_mode_r & boot_end_i
                                   & ~cfg_done_found_i);
    assign ev_set[4] = boot_mode_r & unmapped_load_i;

    // Write one clears, zero keeps, and a new event beats the clear
    // so nothing raised in the clearing cycle is lost
    always @* begin
        flags_nxt = flags_r;
        if (wr_lane3 && adr_i == `SBSF_ADR_STATUS)
            flags_nxt = flags_nxt
                & ~dat_i[`SBSF_FLAG_HI:`SBSF_FLAG_LO];
        flags_nxt = flags_nxt | ev_set;
    end

    always @(posedge clk_i) begin
        if (rst_i)
            flags_r <= `SBSF_FLAGS_RST;
        else
            flags_r <= flags_nxt;
    end

    //------------------------------------------------------------
    // Control and mask registers
    //------------------------------------------------------------
    always @(posedge clk_i) begin
        if (rst_i) begin
            ignore_competing_initiators_r <= 1'b0;
            skip_boot_checksum_r          <= 1'b0;
            mask_r                        <= `SBSF_MASK_RST;
        end else if (wr_lane2 && adr_i == `SBSF_ADR_CONTROL) begin
            ignore_competing_initiators_r <=
                dat_i[`SBSF_BIT_IGN_INI];
            skip_boot_checksum_r <= dat_i[`SBSF_BIT_SKIP_CS];
        end else if (wr_lane3 && adr_i == `SBSF_ADR_IRQ_MASK) begin
            mask_r <= dat_i[`SBSF_FLAG_HI:`SBSF_FLAG_LO];
        end
    end

    //------------------------------------------------------------
    // Read words
    //------------------------------------------------------------
    // Reserved bits are zero; addresses and done are read-only
    assign status_word = {2'b00, flags_r,
                          boot_load_complete_r,
                          8'h00,
                          initiator_port_bus_addr_r,
                          1'b0,
                          target_port_bus_addr_r,
                          1'b0};
    assign control_word = {14'h0000, skip_boot_checksum_r,
                           ignore_competing_initiators_r, 16'h0000};
    assign mask_word    = {2'b00, mask_r, 25'h0000000};

    //------------------------------------------------------------
    // Wishbone answer
    //------------------------------------------------------------
    // One wait state: ack rises the cycle after the request shows
    // and drops the next cycle. Unmapped reads return zero.
    always @(posedge clk_i) begin
        if (rst_i) begin
            ack_r <= 1'b0;
            dat_r <= `SBSF_WORD_ZERO;
        end else begin
            ack_r <= bus_req;
            if (bus_req && !we_i) begin
                if (adr_i == `SBSF_ADR_STATUS)
                    dat_r <= status_word;
                else if (adr_i == `SBSF_ADR_CONTROL)
                    dat_r <= control_word;
                else if (adr_i == `SBSF_ADR_IRQ_MASK)
                    dat_r <= mask_word;
                else
                    dat_r <= `SBSF_WORD_ZERO;
            end
        end
    end

    //------------------------------------------------------------
    // Interrupt
    //------------------------------------------------------------
    // Level output follows the flags enabled in the mask one cycle late
    always @(posedge clk_i) begin
        if (rst_i)
            irq_r <= 1'b0;
        else
            irq_r <= |(flags_r & mask_r);
    end

    assign dat_o         = dat_r;
    assign ack_o         = ack_r;
    assign irq_o         = irq_r;
    assign rearbitrate_o = rearb_r;
    assign abort_o       = abort_r;

endmodule // sbsf_status_flags

`default_nettype wire

// ### sim/sbsf_bus_model.sv
`timescale 1ns/10ps
`default_nettype none
module sbsf_bus_model (
    // Pulled-up serial bus lines
    output logic scl_o,
    output logic sda_o
);
    // Clock stands high between frames, as the pull-ups leave it
    initial begin
        scl_o = 1'b1;
        sda_o = 1'b1;
    end
    // Start, n clocks of 160 ns with toggling data, then a stop
    // Begins 2 ns past the caller's clock edge; every later step is a
    // whole number of clock periods, so no pin moves on an edge
    task automatic frame(input int n);
        #2 sda_o = 1'b0;
        #80 scl_o = 1'b0;
        repeat (n) begin
            sda_o = ~sda_o;
            #40 scl_o = 1'b1;
            #80 scl_o = 1'b0;
            #40;
        end
        sda_o = 1'b0;
        #40 scl_o = 1'b1;
        #80 sda_o = 1'b1;
        #80;
    endtask
endmodule // sbsf_bus_model
`default_nettype wire

// ### sim/sbsf_status_flags_props.sv
`timescale 1ns/10ps
`default_nettype none
module sbsf_status_flags_props (
    // Bus
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic        cyc_i,
    input wire logic        stb_i,
    input wire logic        we_i,
    input wire logic [11:0] adr_i,
    input wire logic [31:0] dat_o,
    input wire logic        ack_o,
    // Straps and arbitration
    input wire logic [6:0]  tgt_addr_strap_i,
    input wire logic [6:0]  ini_addr_strap_i,
    input wire logic        arb_lost_i,
    input wire logic        arb_won_i,
    input wire logic        rearbitrate_o,
    input wire logic        abort_o
);
    default clocking dc @(posedge clk_i); endclocking
    default disable iff (rst_i);
    logic [5:0] loss_r;
    logic       rd_sts;
    assign rd_sts = ack_o && !we_i && adr_i == 12'h424;
    // Losses since a win; the ignore bit only lowers the real count
    always @(posedge clk_i) begin
        if (rst_i || arb_won_i || abort_o)
            loss_r <= {5'h00, arb_lost_i};
        else if (arb_lost_i)
            loss_r <= loss_r + 6'h01;
    end
    ack_answer_a: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
        else $error("no ack one cycle after request");
    ack_single_a: assert property (ack_o |=> !ack_o)
        else $error("ack longer than one cycle");
    read_hold_a: assert property ($changed(dat_o) |-> ack_o)
        else $error("read data moved without ack");
    rsvd_zero_a: assert property (rd_sts |-> dat_o[0] == 1'b0 &&
        dat_o[8] == 1'b0 && dat_o[23:16] == 8'h00 && dat_o[31:30] == 2'h0)
        else $error("reserved status bits not zero");
    tgt_addr_a: assert property (
        rd_sts |-> dat_o[7:1] == tgt_addr_strap_i)
        else $error("target address field wrong");
    ini_addr_a: assert property (
        rd_sts |-> dat_o[15:9] == ini_addr_strap_i)
        else $error("initiator address field wrong");
    retry_cause_a: assert property (
        rearbitrate_o |-> $past(arb_lost_i) && !abort_o)
        else $error("retry without a loss");
    abort_count_a: assert property (
        abort_o |-> $past(arb_lost_i) && loss_r >= 6'h10)
        else $error("abort before sixteen losses");
endmodule // sbsf_status_flags_props
bind sbsf_status_flags sbsf_status_flags_props sbsf_status_flags_props_inst (
    .clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .dat_o, .ack_o,
    .tgt_addr_strap_i, .ini_addr_strap_i, .arb_lost_i, .arb_won_i,
    .rearbitrate_o, .abort_o);
`default_nettype wire

// ### sim/smbus_status_and_error_flags_tb.sv
`timescale 1ns/10ps
`default_nettype none
module smbus_status_and_error_flags_tb;
    // ----------------
    // Stimulus
    // ----------------
    localparam logic [31:0] base = 32'h0000aa54;
    localparam logic [31:0] done = 32'h01000000;
    localparam logic [31:0] nk   = 32'h02000000;
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        cyc_i = 1'b0;
    logic        stb_i = 1'b0;
    logic        we_i  = 1'b0;
    logic [3:0]  sel_i = 4'hf;
    logic [11:0] adr_i = 12'h000;
    logic [31:0] dat_i = 32'h0;
    logic [31:0] rd_q;
    logic [4:0]  ev    = 5'h00;
    logic        bv    = 1'b0;
    logic        cfgd  = 1'b1;
    logic        boot_s = 1'b1;
    logic [7:0]  bb    = 8'h00;
    wire logic [31:0] dat_o;
    wire logic        ack_o, rearb, abort, irq, scl, sda;
    int error_cnt = 0, cmp_count = 0, cyc_n = 0;
    always #4 clk_i = ~clk_i;
    sbsf_bus_model sbsf_bus_model_inst (.scl_o(scl), .sda_o(sda));
    sbsf_status_flags sbsf_status_flags_inst (
        .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
        .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
        .dat_o(dat_o), .ack_o(ack_o), .tgt_addr_strap_i(7'h2a),
        .ini_addr_strap_i(7'h55), .boot_from_eeprom_i(boot_s),
        .nack_seen_i(ev[0]), .arb_lost_i(ev[1]), .arb_won_i(ev[2]),
        .boot_byte_valid_i(bv), .boot_byte_i(bb), .boot_end_i(ev[4]),
        .cfg_done_found_i(cfgd), .unmapped_load_i(ev[3]),
        .scl_pin_i(scl), .sda_pin_i(sda), .rearbitrate_o(rearb),
        .abort_o(abort), .irq_o(irq));
    // ----------------
    // Helpers
    // ----------------
    // Single classic cycle; held until ack is sampled high
    task automatic wb(input logic w, input logic [11:0] a,
                      input logic [31:0] d);
        @(posedge clk_i);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i  <= w;
        sel_i <= 4'hf;
        adr_i <= a;
        dat_i <= d;
        do @(posedge clk_i); while (ack_o !== 1'b1);
        rd_q = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic rdc(input logic [31:0] exp);
        wb(1'b0, 12'h424, 32'h0);
        chk(rd_q, exp);
    endtask
    // One-cycle event pulse; outputs settle 1 ns after the sampling edge
    task automatic pulse(input logic [4:0] m);
        @(posedge clk_i);
        ev <= m;
        @(posedge clk_i);
        ev <= 5'h00;
        #1;
    endtask
    task automatic bbyte(input logic [7:0] b);
        @(posedge clk_i);
        bv <= 1'b1;
        bb <= b;
        @(posedge clk_i);
        bv <= 1'b0;
    endtask
    task automatic wrap_up;
        $display("errors %0d compares %0d", error_cnt, cmp_count);
        if (error_cnt == 0 && cmp_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    // ----------------
    // Scenarios
    // ----------------
    task automatic t_regs;
        rdc(base);
        wb(1'b1, 12'h424, 32'hc0ffffff);
        rdc(base);
        wb(1'b0, 12'h430, 32'h0);
        chk(rd_q, 32'h0);
    endtask
    // Flag stays masked, then raises irq once unmasked
    task automatic t_nack;
        pulse(5'h01);
        rdc(base | nk);
        chk({31'h0, irq}, 32'h0);
        wb(1'b1, 12'h434, nk);
        wb(1'b1, 12'h424, 32'h3c000000);
        rdc(base | nk);
        chk({31'h0, irq}, 32'h1);
        wb(1'b1, 12'h424, nk);
        rdc(base);
        chk({31'h0, irq}, 32'h0);
        wb(1'b1, 12'h434, 32'h0);
    endtask
    // Nine clock pulses end on a byte boundary; five stop mid-byte
    task automatic t_pins;
        sbsf_bus_model_inst.frame(8);
        repeat (10) @(posedge clk_i);
        rdc(base);
        sbsf_bus_model_inst.frame(4);
        repeat (10) @(posedge clk_i);
        rdc(base | 32'h08000000);
        wb(1'b1, 12'h424, 32'h08000000);
    endtask
    // A win in mid-run restarts the count of losses
    task automatic t_arb;
        repeat (10) pulse(5'h02);
        pulse(5'h04);
        for (int i = 1; i <= 16; i++) begin
            pulse(5'h02);
            chk({30'h0, rearb, abort}, i == 16 ? 32'h1 : 32'h2);
        end
        rdc(base | 32'h04000000);
        wb(1'b1, 12'h424, 32'h04000000);
        wb(1'b1, 12'h428, 32'h00010000);
        repeat (20) begin
            pulse(5'h02);
            chk({31'h0, abort}, 32'h0);
        end
        rdc(base);
        wb(1'b1, 12'h428, 32'h0);
    endtask
    task automatic t_boot;
        bbyte(8'h12);
        bbyte(8'h34);
        pulse(5'h10);
        rdc(base | done | 32'h10000000);
        wb(1'b1, 12'h424, 32'h10000000);
        wb(1'b1, 12'h428, 32'h00020000);
        bbyte(8'h55);
        pulse(5'h10);
        rdc(base | done);
        cfgd <= 1'b0;
        pulse(5'h10);
        rdc(base | done | 32'h10000000);
        wb(1'b1, 12'h424, 32'h10000000);
        pulse(5'h08);
        rdc(base | done | 32'h20000000);
    endtask
    // Second reset with the boot strap low: boot events leave no trace
    task automatic t_rst;
        @(posedge clk_i);
        boot_s <= 1'b0;
        rst_i  <= 1'b1;
        repeat (4) @(posedge clk_i);
        rst_i  <= 1'b0;
        pulse(5'h18);
        rdc(base);
    endtask
    // ----------------
    // Run
    // ----------------
    // Hang guard well beyond the expected run length
    always @(posedge clk_i) begin
        cyc_n++;
        if (cyc_n == 20000) begin
            error_cnt++;
            wrap_up;
        end
    end
    initial begin
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        t_regs;
        t_nack;
        t_pins;
        t_arb;
        t_boot;
        t_rst;
        wrap_up;
    end
endmodule // smbus_status_and_error_flags_tb
`default_nettype wire
